/* File: rmi_top.sv */
// Remote digital input controller with AHB-Lite register access
// Overview of operation
// [R1] Ten inputs, each given one function
// [R2] Ignore inputs unless remote control enabled
// [R3] Remote enable set only from front panel
// [R4] Unassigned input never affects the transmitter
// [R5] RF function turns carrier on if available
// [R6] Reset function triggers full system reset
// [R7] Power function steps carrier up or down
// [R8] Main exciter function picks exciter A or B
// [R9] Changeover function sets automatic exciter changeover
// [R10] Scheduler function enables or disables scheduler
// [R11] Lockout function sets one of eight, always
// [R12] Preset function makes named preset active
// [R13] Present level of each input readable
// [R14] Turn-on modes act on high/rise or low/fall
// [R15] Turn-off modes deactivate on high/rise or low/fall
// [R16] Toggle modes alternate state on qualifying edges
// [R17] Two-edge modes: one edge on, other off
// [R18] Level power modes step while held active
// [R19] Level turn-on modes activate while held active
// [R20] Apply commits settings; cancel restores active ones
// [R21] Synchronise inputs, derive edges from samples
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`default_nettype none
module rmi_top #(
  parameter int N_IN = rmi_pkg::N_IN
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Remote input pins and local controls
  input wire logic [N_IN-1:0] remote_in,
  input wire logic remote_enable,
  input wire logic rf_available,
  // Transmitter requests
  output logic carrier_output_switch,
  output logic sys_reset_req,
  output logic output_power_step_inc,
  output logic output_power_step_dec,
  output logic exciter_b_sel,
  output logic auto_changeover,
  output logic scheduler_en,
  output logic [rmi_pkg::N_LOCK-1:0] lockout_active,
  output logic [rmi_pkg::ARG_W-1:0] preset_sel,
  output logic preset_load
);
  localparam int CW = rmi_pkg::CFG_W;
  localparam int AW = rmi_pkg::ARG_W;
  localparam int NL = rmi_pkg::N_LOCK;

  // ==========================================================
  // Bus address phase
  logic addr_ok, wr_q, rd_unused;
  logic [7:0] wa_q;
  logic [31:0] rdata_d, hrdata_q;
  logic [3:0] ra_idx, wa_idx;
  logic ra_pend, ra_act, wa_pend, wa_cmd;
  logic [N_IN-1:0][CW-1:0] cfg_pend_q, cfg_act_q;
  logic apply_cmd, cancel_cmd;

  // Zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_unused = |hsize;

  // Read decode on the address phase so data sits in a flop for the data phase
  assign ra_idx = haddr[5:2];
  assign ra_pend = haddr[7:6] == rmi_pkg::REGION_PEND && 32'(ra_idx) < N_IN;
  assign ra_act = haddr[7:6] == rmi_pkg::REGION_ACT && 32'(ra_idx) < N_IN;

  // ==========================================================
  // Input sampling and per-channel evaluation
  logic [N_IN-1:0] lvl, rise, fall, act_raw, deact_raw, act_g, deact_g;
  logic [N_IN-1:0] is_rf, is_rst, is_pwr, is_exc, is_auto, is_sched, is_lock, is_pre;
  logic [N_IN-1:0][NL-1:0] lock_set_oh, lock_clr_oh;
  logic [N_IN-1:0] allowed;

  // Status word assembled from live state
  logic [31:0] state_word;
  assign state_word = {8'h00, 5'h00, preset_sel, lockout_active, 3'h0, remote_enable,
                       scheduler_en, auto_changeover, exciter_b_sel, carrier_output_switch};

  // Read mux; unmapped addresses read zero
  assign rdata_d = (haddr[7:0] == rmi_pkg::OFS_LEVEL) ? 32'(lvl) // [R13]
    : (haddr[7:0] == rmi_pkg::OFS_STATE) ? state_word
    : ra_pend ? 32'(cfg_pend_q[ra_idx])
    : ra_act ? 32'(cfg_act_q[ra_idx])
    : 32'h0000_0000;

  // Address phase capture, read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_ok && hwrite;
      wa_q <= haddr[7:0];
      hrdata_q <= (addr_ok && !hwrite) ? rdata_d : hrdata_q;
    end
  end

  // ==========================================================
  // Write data phase decode
  assign wa_idx = wa_q[5:2];
  assign wa_pend = wr_q && wa_q[7:6] == rmi_pkg::REGION_PEND && 32'(wa_idx) < N_IN;
  assign wa_cmd = wr_q && wa_q == rmi_pkg::OFS_CMD;
  assign apply_cmd = wa_cmd && hwdata[rmi_pkg::CMD_APPLY_BIT]; // [R20]
  assign cancel_cmd = wa_cmd && hwdata[rmi_pkg::CMD_CANCEL_BIT] && !apply_cmd; // [R20]

  // Edited settings live apart from the ones in force until applied
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_pend_q <= {N_IN{rmi_pkg::CFG_RST}};
      cfg_act_q <= {N_IN{rmi_pkg::CFG_RST}};
    end else begin
      if (wa_pend) begin
        cfg_pend_q[wa_idx] <= hwdata[CW-1:0];
      end else if (cancel_cmd) begin
        cfg_pend_q <= cfg_act_q; // [R20]
      end
      if (apply_cmd) begin
        cfg_act_q <= cfg_pend_q; // [R20]
      end
    end
  end

  // Synchronise all pins together
  rmi_sync #(
    .W(N_IN)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(remote_in),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // One evaluator and one function decode per input
  for (genvar i = 0; i < N_IN; i++) begin : g_ch
    logic [rmi_pkg::FUNC_W-1:0] fn;
    logic [AW-1:0] arg;
    assign fn = cfg_act_q[i][rmi_pkg::CFG_FUNC_LSB +: rmi_pkg::FUNC_W]; // [R1]
    assign arg = cfg_act_q[i][rmi_pkg::CFG_ARG_LSB +: AW];

    rmi_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(apply_cmd),
      .mode(cfg_act_q[i][rmi_pkg::CFG_MODE_LSB +: rmi_pkg::MODE_W]),
      .level(lvl[i]),
      .rise(rise[i]),
      .fall(fall[i]),
      .act(act_raw[i]),
      .deact(deact_raw[i])
    );

    // Unassigned code matches no function, so it reaches nothing
    assign is_rf[i] = fn == rmi_pkg::F_RF; // [R4]
    assign is_rst[i] = fn == rmi_pkg::F_RESET;
    assign is_pwr[i] = fn == rmi_pkg::F_PWR;
    assign is_exc[i] = fn == rmi_pkg::F_MAIN_EXC;
    assign is_auto[i] = fn == rmi_pkg::F_AUTO_CHG;
    assign is_sched[i] = fn == rmi_pkg::F_SCHED;
    assign is_lock[i] = fn == rmi_pkg::F_LOCKOUT;
    assign is_pre[i] = fn == rmi_pkg::F_PRESET;
    // Remote enable is a front-panel pin only; lockout ignores it
    assign allowed[i] = remote_enable || is_lock[i]; // [R2] [R3] [R11]
    assign act_g[i] = act_raw[i] && allowed[i]; // [R2]
    assign deact_g[i] = deact_raw[i] && allowed[i]; // [R2]
    assign lock_set_oh[i] = (act_g[i] && is_lock[i]) ? NL'(1) << arg : '0; // [R11]
    assign lock_clr_oh[i] = (deact_g[i] && is_lock[i]) ? NL'(1) << arg : '0;
  end

  // ==========================================================
  // Merge requests per function
  logic rf_on, rf_off, rst_act, inc_act, dec_act, exc_b, exc_a;
  logic auto_on, auto_off, sched_on, sched_off, pre_hit;
  logic [NL-1:0] lock_set, lock_clr;
  logic [AW-1:0] pre_idx;

  assign rf_on = |(act_g & is_rf) && rf_available; // [R5]
  assign rf_off = |(deact_g & is_rf);
  assign rst_act = |(act_g & is_rst); // [R6]
  assign inc_act = |(act_g & is_pwr); // [R7]
  assign dec_act = |(deact_g & is_pwr) && !inc_act; // [R7]
  assign exc_b = |(act_g & is_exc); // [R8]
  assign exc_a = |(deact_g & is_exc); // [R8]
  assign auto_on = |(act_g & is_auto); // [R9]
  assign auto_off = |(deact_g & is_auto);
  assign sched_on = |(act_g & is_sched); // [R10]
  assign sched_off = |(deact_g & is_sched); // [R10]
  assign pre_hit = |(act_g & is_pre); // [R12]

  // OR of lockout requests; lowest preset channel wins a tie
  always_comb begin
    lock_set = '0;
    lock_clr = '0;
    pre_idx = rmi_pkg::PRESET_RST;
    for (int i = N_IN - 1; i >= 0; i--) begin
      lock_set = lock_set | lock_set_oh[i];
      lock_clr = lock_clr | lock_clr_oh[i];
      if (act_g[i] && is_pre[i]) begin
        pre_idx = cfg_act_q[i][rmi_pkg::CFG_ARG_LSB +: AW];
      end
    end
  end

  // ==========================================================
  // Function state; activation beats deactivation in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carrier_output_switch <= 1'b0;
      sys_reset_req <= 1'b0;
      output_power_step_inc <= 1'b0;
      output_power_step_dec <= 1'b0;
      exciter_b_sel <= 1'b0;
      auto_changeover <= 1'b0;
      scheduler_en <= 1'b0;
      lockout_active <= '0;
      preset_sel <= rmi_pkg::PRESET_RST;
      preset_load <= 1'b0;
    end else begin
      carrier_output_switch <= rf_on || (carrier_output_switch && !rf_off); // [R5]
      sys_reset_req <= rst_act; // [R6]
      output_power_step_inc <= inc_act; // [R18]
      output_power_step_dec <= dec_act; // [R18]
      exciter_b_sel <= exc_b || (exciter_b_sel && !exc_a); // [R8]
      auto_changeover <= auto_on || (auto_changeover && !auto_off); // [R9]
      scheduler_en <= sched_on || (scheduler_en && !sched_off); // [R10]
      lockout_active <= lock_set | (lockout_active & ~lock_clr); // [R11]
      preset_sel <= pre_hit ? pre_idx : preset_sel; // [R12]
      preset_load <= pre_hit; // [R12]
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Held function state; the preset pulse is checked on its own
  logic [8:0] fn_state;
  assign fn_state = {carrier_output_switch, exciter_b_sel, auto_changeover, scheduler_en,
                     lockout_active[1:0], preset_sel};

  sequence s_read_level;
    addr_ok && !hwrite && haddr[7:0] == rmi_pkg::OFS_LEVEL;
  endsequence
  sequence s_apply_write;
    wa_cmd && hwdata[rmi_pkg::CMD_APPLY_BIT];
  endsequence

  a_level_readback: assert property (s_read_level ##1 1'b1 |-> // [R13]
      hrdata[N_IN-1:0] == $past(lvl) && hrdata[31:N_IN] == '0)
    else $error("level register does not show synced inputs");
  a_remote_gate: assert property (!remote_enable && !(|is_lock) |=> // [R2]
      $stable(fn_state) && !sys_reset_req && !output_power_step_inc && !preset_load)
    else $error("remote input acted while remote control disabled");
  a_unassigned_idle: assert property (apply_cmd && cfg_pend_q == '0 ##1 1'b1 |=> // [R4]
      $stable(fn_state) && !sys_reset_req && !preset_load)
    else $error("unassigned inputs changed transmitter state");
  a_rf_turn_on: assert property (|(act_g & is_rf) && rf_available && !apply_cmd |=> // [R5]
      carrier_output_switch)
    else $error("RF turn-on request ignored");
  a_reset_pulse: assert property (rst_act |=> sys_reset_req) // [R6]
    else $error("reset function did not raise reset request");
  a_power_step: assert property (inc_act |=> output_power_step_inc && !output_power_step_dec) // [R7]
    else $error("power increase request lost or conflicted");
  a_lockout_any: assert property (|lock_set |=> // [R11]
      (lockout_active & $past(lock_set)) == $past(lock_set))
    else $error("lockout limit not set");
  a_apply_commit: assert property (s_apply_write |=> cfg_act_q == $past(cfg_pend_q)) // [R20]
    else $error("apply did not commit pending settings");
  a_cancel_restore: assert property (cancel_cmd && !wa_pend |=> cfg_pend_q == $past(cfg_act_q)) // [R20]
    else $error("cancel did not restore active settings");

  // ==========================================================
  // Set and clear paths; a set in the same cycle wins
  a_rf_off: assert property (rf_off && !rf_on |=> !carrier_output_switch) // [R5]
    else $error("RF off request ignored");
  a_rf_blocked: assert property (!rf_available && !carrier_output_switch |=> // [R5]
      !carrier_output_switch)
    else $error("RF on while unavailable");
  a_exciter_b: assert property (exc_b |=> exciter_b_sel) // [R8]
    else $error("exciter B not selected");
  a_exciter_a: assert property (exc_a && !exc_b |=> !exciter_b_sel) // [R8]
    else $error("exciter A not selected");
  a_auto_on: assert property (auto_on |=> auto_changeover) // [R9]
    else $error("changeover not set");
  a_auto_off: assert property (auto_off && !auto_on |=> !auto_changeover) // [R9]
    else $error("changeover not cleared");
  a_sched_on: assert property (sched_on |=> scheduler_en) // [R10]
    else $error("scheduler not enabled");
  a_sched_off: assert property (sched_off && !sched_on |=> !scheduler_en) // [R10]
    else $error("scheduler not disabled");
  a_lock_local: assert property (|(act_raw & is_lock) |-> |lock_set) // [R11]
    else $error("lockout input was gated");
  a_lock_hold: assert property (!(|lock_clr) |=> // [R11]
      (lockout_active & $past(lockout_active)) == $past(lockout_active))
    else $error("lockout limit dropped");

  // Pulse outputs drop as soon as their request goes away
  a_reset_quiet: assert property (!rst_act |=> !sys_reset_req) // [R6]
    else $error("reset request without cause");
  a_inc_quiet: assert property (!inc_act |=> !output_power_step_inc) // [R7]
    else $error("increase without cause");
  a_power_dec: assert property (dec_act |=> // [R7]
      output_power_step_dec && !output_power_step_inc)
    else $error("power decrease lost");
  a_preset_pick: assert property (pre_hit |=> // [R12]
      preset_load && preset_sel == $past(pre_idx))
    else $error("preset not loaded");
  a_preset_hold: assert property (!pre_hit |=> !preset_load && $stable(preset_sel)) // [R12]
    else $error("preset changed without cause");

  // A single preset edge gives a single load pulse
  sequence s_preset_once;
    pre_hit ##1 !pre_hit;
  endsequence
  a_preset_once: assert property (s_preset_once |=> !preset_load) // [R12]
    else $error("preset load stretched");
  a_pend_write: assert property (wa_pend |=> // [R20]
      cfg_pend_q[$past(wa_idx)] == $past(hwdata[CW-1:0]))
    else $error("pending write lost");
endmodule
`default_nettype wire

/* File: rmi_pkg.sv */
// Constants, register map and encodings of the remote input controller
`default_nettype none
package rmi_pkg;
  // ==========================================================
  // Sizes
  localparam int N_IN = 10;
  localparam int FUNC_W = 4;
  localparam int MODE_W = 4;
  localparam int ARG_W = 3;
  localparam int CFG_W = FUNC_W + MODE_W + ARG_W;
  localparam int N_LOCK = 8;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [1:0] REGION_PEND = 2'h1;
  localparam logic [1:0] REGION_ACT = 2'h2;
  // ==========================================================
  // Field positions
  localparam int CMD_APPLY_BIT = 0;
  localparam int CMD_CANCEL_BIT = 1;
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_ARG_LSB = 8;
  localparam int ST_RF_BIT = 0;
  localparam int ST_EXCB_BIT = 1;
  localparam int ST_AUTO_BIT = 2;
  localparam int ST_SCHED_BIT = 3;
  localparam int ST_REMEN_BIT = 4;
  localparam int ST_LOCK_LSB = 8;
  localparam int ST_PRESET_LSB = 16;
  // ==========================================================
  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST = 11'h000;
  localparam logic [ARG_W-1:0] PRESET_RST = 3'h0;
  // ==========================================================
  // Channel functions
  typedef enum logic [FUNC_W-1:0] {
    F_NONE = 4'h0, F_RF = 4'h1, F_RESET = 4'h2, F_PWR = 4'h3, F_MAIN_EXC = 4'h4,
    F_AUTO_CHG = 4'h5, F_SCHED = 4'h6, F_LOCKOUT = 4'h7, F_PRESET = 4'h8
  } rmi_func_e;
  // Polarity and edge modes
  typedef enum logic [MODE_W-1:0] {
    M_RISE_ON = 4'h0, M_FALL_ON = 4'h1, M_RISE_OFF = 4'h2, M_FALL_OFF = 4'h3,
    M_FALL_TOG = 4'h4, M_RISE_TOG = 4'h5, M_RISE_ON_FALL_OFF = 4'h6,
    M_FALL_ON_RISE_OFF = 4'h7, M_HI_INC = 4'h8, M_LO_INC = 4'h9, M_HI_DEC = 4'ha,
    M_LO_DEC = 4'hb, M_HI_ON = 4'hc, M_LO_ON = 4'hd
  } rmi_mode_e;
endpackage
`default_nettype wire

/* File: rmi_sync.sv */
// Input synchroniser with edge detection on the settled stages
`default_nettype none
module rmi_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw pins and results
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q, sync_q, prev_q;

  // Two-flop sync plus one history stage; edges never look at meta_q
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges from consecutive settled samples
  assign level = sync_q;
  assign rise = sync_q & ~prev_q; // [R21]
  assign fall = ~sync_q & prev_q; // [R21]

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_edge_source: assert property (|rise |-> ##1 ((prev_q & $past(rise)) == $past(rise))) // [R21]
    else $error("rise without a following high history sample");
endmodule
`default_nettype wire

/* File: rmi_chan.sv */
// Per-input mode evaluator: turns level and edges into activate and deactivate requests
`default_nettype none
module rmi_chan (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration
  input wire logic clear,
  input wire logic [rmi_pkg::MODE_W-1:0] mode,
  // Sampled input
  input wire logic level,
  input wire logic rise,
  input wire logic fall,
  // Requests
  output logic act,
  output logic deact
);
  logic tog_q, tog_d;
  logic is_rtog, is_ftog, tog_ev;

  // Toggle modes: rising starts by activating, falling starts by deactivating
  assign is_rtog = mode == rmi_pkg::M_RISE_TOG;
  assign is_ftog = mode == rmi_pkg::M_FALL_TOG;
  assign tog_ev = (is_rtog && rise) || (is_ftog && fall); // [R16]
  assign tog_d = clear ? 1'b0 : (tog_ev ? ~tog_q : tog_q);

  // Activation: edge, two-edge, toggle and held-level modes
  assign act = (mode == rmi_pkg::M_RISE_ON && rise) // [R14]
    || (mode == rmi_pkg::M_FALL_ON && fall) // [R14]
    || (mode == rmi_pkg::M_RISE_ON_FALL_OFF && rise) // [R17]
    || (mode == rmi_pkg::M_FALL_ON_RISE_OFF && fall) // [R17]
    || (is_rtog && rise && !tog_q) || (is_ftog && fall && tog_q) // [R16]
    || ((mode == rmi_pkg::M_HI_INC || mode == rmi_pkg::M_HI_ON) && level) // [R18] [R19]
    || ((mode == rmi_pkg::M_LO_INC || mode == rmi_pkg::M_LO_ON) && !level); // [R18] [R19]
  // Deactivation counterparts
  assign deact = (mode == rmi_pkg::M_RISE_OFF && rise) // [R15]
    || (mode == rmi_pkg::M_FALL_OFF && fall) // [R15]
    || (mode == rmi_pkg::M_RISE_ON_FALL_OFF && fall) // [R17]
    || (mode == rmi_pkg::M_FALL_ON_RISE_OFF && rise) // [R17]
    || (is_rtog && rise && tog_q) || (is_ftog && fall && !tog_q) // [R16]
    || (mode == rmi_pkg::M_HI_DEC && level) || (mode == rmi_pkg::M_LO_DEC && !level); // [R18]

  // Toggle history, restarted whenever settings are applied
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_first_rise;
    is_rtog && rise && !tog_q && !clear;
  endsequence
  a_toggle_alternates: assert property (s_first_rise |-> act ##1 tog_q) // [R16]
    else $error("rising toggle did not activate then arm deactivation");
  a_edge_turn_on: assert property ((mode == rmi_pkg::M_FALL_ON && fall) |-> act && !deact) // [R14]
    else $error("falling edge turn-on did not activate");
endmodule
`default_nettype wire

/* File: rmi_remote_eq.sv */
// Behavioural model of the remote control equipment that drives the input lines
`default_nettype none
module rmi_remote_eq #(
  parameter int W = 10
) (
  // Clock
  input wire logic hclk,
  // Lines towards the controller
  output logic [W-1:0] remote_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Line drivers
  // Contacts are driven at all times, so no line ever floats
  initial remote_in = '0;
  // Slow equipment waits dly edges; every change lands just after an edge
  task automatic put(input int i, input logic v, input int dly);
    repeat (dly) @(posedge hclk);
    remote_in[i] <= v;
  endtask
endmodule
`default_nettype wire

/* File: remote_input_control_tb_top.sv */
// Self-checking bench for the remote input controller
`default_nettype none
module remote_input_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite, remote_enable, rf_available;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, carrier_output_switch, sys_reset_req, preset_load;
  logic output_power_step_inc, output_power_step_dec, exciter_b_sel;
  logic auto_changeover, scheduler_en;
  logic [7:0] lockout_active;
  logic [2:0] preset_sel;
  logic [9:0] remote_in;
  logic [31:0] cfg [10];
  int num_errors, tests_run, n_rst, n_pl;
  // ==========================================================
  // Design and far-side equipment
  rmi_top #(.N_IN(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .remote_in(remote_in),
    .remote_enable(remote_enable), .rf_available(rf_available),
    .carrier_output_switch(carrier_output_switch), .sys_reset_req(sys_reset_req),
    .output_power_step_inc(output_power_step_inc),
    .output_power_step_dec(output_power_step_dec), .exciter_b_sel(exciter_b_sel),
    .auto_changeover(auto_changeover), .scheduler_en(scheduler_en),
    .lockout_active(lockout_active), .preset_sel(preset_sel), .preset_load(preset_load));
  rmi_remote_eq #(.W(10)) eq_u (.hclk(hclk), .remote_in(remote_in));
  // Clock at 250 MHz
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Pulse counters, since one-cycle requests are easy to miss by polling
  always @(posedge hclk) begin
    if (sys_reset_req === 1'b1) n_rst++;
    if (preset_load === 1'b1) n_pl++;
  end
  // ==========================================================
  // Reporting
  task automatic end_sim();
    $display("Errors %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // ==========================================================
  // Bus master
  // Bounded wait for hready high at a rising edge
  task automatic wrdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wrdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wrdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] t;
    bus(1'b0, a, 32'h0, t);
    chk(t, exp, what);
    chk(32'(hresp), 32'h0, "bus response");
  endtask
  // Move one line and let the two-flop path and output register settle
  task automatic pin(input int i, input logic v);
    eq_u.put(i, v, i % 3);
    repeat (6) @(posedge hclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    remote_enable = 1'b0;
    rf_available = 1'b1;
    hresetn = 1'b0;
    cfg = '{32'h001, 32'h012, 32'h083, 32'h064, 32'h055, 32'h016, 32'h507, 32'h308,
      32'h000, 32'h0b3};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    rdc(rmi_pkg::OFS_STATE, 32'h0, "state after reset");
    rdc(8'h10, 32'h0, "unmapped read");
    wr(rmi_pkg::OFS_CMD, 32'h1);
    // Pending setting dropped by cancel
    wr(8'h40, 32'h001);
    rdc(8'h40, 32'h001, "pending written");
    wr(rmi_pkg::OFS_CMD, 32'h2);
    rdc(8'h40, 32'h0, "pending after cancel");
    // Ten inputs configured, active only after apply
    for (int i = 0; i < 10; i++) wr(8'h40 + 8'(4 * i), cfg[i]);
    rdc(8'h80, 32'h0, "active before apply");
    wr(rmi_pkg::OFS_CMD, 32'h1);
    for (int i = 0; i < 10; i++) rdc(8'h80 + 8'(4 * i), cfg[i], "active cfg");
    // Remote disabled: only the lockout acts
    repeat (6) @(posedge hclk);
    chk(32'(output_power_step_dec), 32'h0, "dec while disabled");
    pin(0, 1'b1);
    pin(6, 1'b1);
    chk(32'(lockout_active), 32'h20, "lockout");
    rdc(rmi_pkg::OFS_STATE, 32'h2000, "state while disabled");
    // Enable remote: level power modes
    remote_enable <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(32'(output_power_step_dec), 32'h1, "low dec held");
    chk(32'(carrier_output_switch), 32'h0, "old edge not queued");
    pin(9, 1'b1);
    chk(32'(output_power_step_dec), 32'h0, "dec released");
    pin(2, 1'b1);
    chk(32'(output_power_step_inc), 32'h1, "high inc held");
    pin(2, 1'b0);
    chk(32'(output_power_step_inc), 32'h0, "inc released");
    // RF switching, with and without availability
    rf_available <= 1'b0;
    pin(0, 1'b0);
    pin(0, 1'b1);
    chk(32'(carrier_output_switch), 32'h0, "rf unavailable");
    rf_available <= 1'b1;
    pin(0, 1'b0);
    pin(0, 1'b1);
    chk(32'(carrier_output_switch), 32'h1, "rf on rising");
    rdc(rmi_pkg::OFS_LEVEL, 32'h241, "input levels");
    // Reset on falling edge only
    pin(1, 1'b1);
    pin(1, 1'b0);
    chk(n_rst, 32'h1, "reset pulses");
    // Exciter select on two edges
    pin(3, 1'b1);
    chk(32'(exciter_b_sel), 32'h1, "exciter b");
    pin(3, 1'b0);
    chk(32'(exciter_b_sel), 32'h0, "exciter a");
    // Changeover toggles on rising edges
    pin(4, 1'b1);
    chk(32'(auto_changeover), 32'h1, "toggle first");
    pin(4, 1'b0);
    pin(4, 1'b1);
    chk(32'(auto_changeover), 32'h0, "toggle second");
    // Scheduler on by falling edge, off by rising edge after new mode
    pin(5, 1'b1);
    pin(5, 1'b0);
    chk(32'(scheduler_en), 32'h1, "scheduler on");
    wr(8'h54, 32'h026);
    wr(rmi_pkg::OFS_CMD, 32'h1);
    pin(5, 1'b1);
    chk(32'(scheduler_en), 32'h0, "scheduler off");
    // Preset selection
    pin(7, 1'b1);
    chk(32'(preset_sel), 32'h3, "preset index");
    chk(n_pl, 32'h1, "preset load pulses");
    // Unassigned input changes nothing
    pin(8, 1'b1);
    pin(8, 1'b0);
    rdc(rmi_pkg::OFS_STATE, 32'h32011, "state after unassigned");
    chk(n_rst, 32'h1, "no extra reset");
    // Second setting set: the modes not used so far
    wr(8'h40, 32'h031);
    wr(8'h48, 32'h093);
    wr(8'h4c, 32'h074);
    wr(8'h50, 32'h045);
    wr(8'h54, 32'h0c6);
    wr(8'h60, 32'h1d7);
    wr(8'h64, 32'h0a3);
    wr(rmi_pkg::OFS_CMD, 32'h1);
    repeat (6) @(posedge hclk);
    chk(32'(scheduler_en), 32'h1, "high turn-on");
    chk(32'(output_power_step_inc), 32'h1, "low inc held");
    chk(32'(output_power_step_dec), 32'h0, "inc beats dec");
    chk(32'(lockout_active), 32'h22, "low lockout");
    pin(2, 1'b1);
    chk(32'(output_power_step_dec), 32'h1, "high dec held");
    pin(0, 1'b0);
    chk(32'(carrier_output_switch), 32'h0, "rf off falling");
    pin(3, 1'b1);
    pin(3, 1'b0);
    chk(32'(exciter_b_sel), 32'h1, "exciter b falling");
    pin(3, 1'b1);
    chk(32'(exciter_b_sel), 32'h0, "exciter a rising");
    pin(4, 1'b1);
    pin(4, 1'b0);
    pin(4, 1'b1);
    pin(4, 1'b0);
    chk(32'(auto_changeover), 32'h1, "falling toggle");
    end_sim();
  end
endmodule
`default_nettype wire
